// [src/ctc_regs.svh]
// Constants for the core tile control block
`ifndef CTC_REGS_SVH
`define CTC_REGS_SVH
`define CTC_NUM_CORES 8
`define CTC_CORE_W 3
`define CTC_PS_COUNT 32'h00000008
`define CTC_PS_IDX_W 3
`define CTC_PS_RESET 32'h00000000
`define CTC_TILE_W 16
`define CTC_SWREG_W 8
`define CTC_MISS_W 4
`endif

// [src/ctc_pkg.sv]
// Types for the core tile control block
`include "ctc_regs.svh"
package ctc_pkg;
  typedef enum logic [2:0] {
    CTC_OP_NOP = 3'h0,
    CTC_OP_FAST_ON = 3'h1,
    CTC_OP_FAST_OFF = 3'h2,
    CTC_OP_PS_RD = 3'h3,
    CTC_OP_PS_WR = 3'h4,
    CTC_OP_SW_RD = 3'h5
  } ctc_op_t;
  typedef enum logic [1:0] {
    CTC_ST_IDLE = 2'h0,
    CTC_ST_SW_REQ = 2'h1,
    CTC_ST_SW_WAIT = 2'h2
  } ctc_state_t;
  typedef struct packed {
    ctc_op_t op;
    logic [`CTC_CORE_W-1:0] core;
    logic [31:0] reg_num;
    logic [31:0] data;
    logic [31:0] tile;
  } ctc_cmd_t;
  typedef struct packed {
    logic [31:0] data;
    logic status;
    logic exception;
  } ctc_rsp_t;
  typedef struct packed {
    logic [`CTC_TILE_W-1:0] tile;
    logic [`CTC_SWREG_W-1:0] reg_num;
  } ctc_swreq_t;
  typedef struct packed {
    logic error;
    logic [31:0] data;
  } ctc_swack_t;
endpackage

// [src/ctc_sched.sv]
// Round-robin issue slot scheduler
`timescale 1ns/1ps
`default_nettype none
`include "ctc_regs.svh"
module ctc_sched
  import ctc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [`CTC_NUM_CORES-1:0] active_in,
  input wire logic [`CTC_NUM_CORES-1:0] wait_in,
  input wire logic [`CTC_NUM_CORES-1:0] fast_in,
  output logic slot_valid_out,
  output logic [`CTC_CORE_W-1:0] slot_core_out,
  output logic slot_issue_out
);
  logic [`CTC_NUM_CORES-1:0] elig;
  logic [`CTC_CORE_W-1:0] ptr_q, ptr_d, cand;
  logic found;
  logic valid_q, valid_d, issue_q, issue_d, fast_pick_q, fast_pick_d;
  logic [`CTC_MISS_W-1:0] miss0_q, miss0_d;

  always_comb begin
    elig = active_in & (~wait_in | fast_in);
    found = 1'b0;
    ptr_d = ptr_q;
    cand = ptr_q;
    for (int k = 1; k <= `CTC_NUM_CORES; k++) begin
      cand = ptr_q + k[`CTC_CORE_W-1:0];
      if (!found && elig[cand]) begin
        found = 1'b1;
        ptr_d = cand;
      end
    end
    valid_d = found;
    issue_d = found && !wait_in[ptr_d];
    fast_pick_d = found && fast_in[ptr_d];
    miss0_d = miss0_q;
    if (!(active_in[0] && fast_in[0]) || (found && ptr_d == '0)) begin
      miss0_d = '0;
    end else if (miss0_q != '1) begin
      miss0_d = miss0_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ptr_q <= '0;
      valid_q <= 1'b0;
      issue_q <= 1'b0;
      fast_pick_q <= 1'b0;
      miss0_q <= '0;
    end else begin
      ptr_q <= ptr_d;
      valid_q <= valid_d;
      issue_q <= issue_d;
      fast_pick_q <= fast_pick_d;
      miss0_q <= miss0_d;
    end
  end

  assign slot_valid_out = valid_q;
  assign slot_core_out = ptr_q;
  assign slot_issue_out = issue_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  fast_slot_kept_a: assert property (miss0_q <= 4'h8)
    else $error("fast core 0 went a full round without a slot");
  wait_slot_only_fast_a: assert property (
    slot_valid_out && !slot_issue_out |-> fast_pick_q)
    else $error("waiting normal core held a slot");
endmodule
`default_nettype wire

// [src/ctc_top.sv]
// Core tile control: fast mode, state registers and switch reads
// Notes on behaviour
// - A fast-mode core gets an issue slot every round, even while waiting.
// - Waiting fast core keeps its slot; waiting normal core frees it.
// - Fast-mode enable sets the flag of the issuing core only.
// - Fast-mode disable returns the issuing core to normal mode.
// - State read returns the selected register, or an exception if illegal.
// - State write loads the selected register, or an exception if illegal.
// - Switch read goes to the given tile; good acknowledgement returns data, status 1.
// - Error acknowledgement or unencodable register or tile gives status 0.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_regs.svh"
module ctc_top
  import ctc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  input wire ctc_cmd_t cmd_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output ctc_rsp_t rsp_out,
  input wire logic [`CTC_NUM_CORES-1:0] active_in,
  input wire logic [`CTC_NUM_CORES-1:0] wait_in,
  output logic [`CTC_NUM_CORES-1:0] fast_out,
  output logic slot_valid_out,
  output logic [`CTC_CORE_W-1:0] slot_core_out,
  output logic slot_issue_out,
  output logic req_valid_out,
  output ctc_swreq_t req_out,
  input wire logic req_ready_in,
  input wire logic ack_valid_in,
  input wire ctc_swack_t ack_in
);
  ctc_state_t state_q, state_d;
  logic take;
  logic ps_legal;
  logic [`CTC_PS_IDX_W-1:0] ps_idx;
  logic [31:0] ps_q [`CTC_PS_COUNT];
  logic [31:0] ps_d [`CTC_PS_COUNT];
  logic [31:0] ps_rd_val;
  logic [`CTC_NUM_CORES-1:0] fast_q;
  logic [`CTC_NUM_CORES-1:0] core_mask;
  logic sw_ovf;
  logic rsp_valid_q, rsp_valid_d;
  ctc_rsp_t rsp_q, rsp_d;
  ctc_swreq_t req_q, req_d;

  assign take = cmd_valid_in && cmd_ready_out;
  assign cmd_ready_out = (state_q == CTC_ST_IDLE);
  assign ps_legal = (cmd_in.reg_num < `CTC_PS_COUNT);
  assign ps_idx = cmd_in.reg_num[`CTC_PS_IDX_W-1:0];
  assign ps_rd_val = ps_q[ps_idx];
  assign core_mask = `CTC_NUM_CORES'(1) << cmd_in.core;
  assign sw_ovf = (|cmd_in.tile[31:`CTC_TILE_W]) || (|cmd_in.reg_num[31:`CTC_SWREG_W]);

  // Fast-mode flag per logical core
  for (genvar i = 0; i < `CTC_NUM_CORES; i++) begin : g_fast
    localparam logic [`CTC_CORE_W-1:0] CID = `CTC_CORE_W'(i);
    logic flag_q, flag_d;
    always_comb begin
      flag_d = flag_q;
      if (take && cmd_in.core == CID) begin
        if (cmd_in.op == CTC_OP_FAST_ON) begin
          flag_d = 1'b1;
        end else if (cmd_in.op == CTC_OP_FAST_OFF) begin
          flag_d = 1'b0;
        end
      end
    end
    always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
        flag_q <= 1'b0;
      end else begin
        flag_q <= flag_d;
      end
    end
    assign fast_q[i] = flag_q;
  end

  assign fast_out = fast_q;

  // Processor state registers
  always_comb begin
    ps_d = ps_q;
    if (take && cmd_in.op == CTC_OP_PS_WR && ps_legal) begin
      ps_d[ps_idx] = cmd_in.data;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      for (int j = 0; j < `CTC_PS_COUNT; j++) begin
        ps_q[j] <= `CTC_PS_RESET;
      end
    end else begin
      ps_q <= ps_d;
    end
  end

  // Command sequencing and switch read
  always_comb begin
    state_d = state_q;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    req_d = req_q;
    case (state_q)
      CTC_ST_IDLE: begin
        if (take) begin
          rsp_d = '0;
          case (cmd_in.op)
            CTC_OP_FAST_ON, CTC_OP_FAST_OFF: begin
              rsp_valid_d = 1'b1;
              rsp_d.status = 1'b1;
            end
            CTC_OP_PS_RD: begin
              rsp_valid_d = 1'b1;
              if (ps_legal) begin
                rsp_d.data = ps_rd_val;
                rsp_d.status = 1'b1;
              end else begin
                rsp_d.exception = 1'b1;
              end
            end
            CTC_OP_PS_WR: begin
              rsp_valid_d = 1'b1;
              rsp_d.status = ps_legal;
              rsp_d.exception = !ps_legal;
            end
            CTC_OP_SW_RD: begin
              if (sw_ovf) begin
                rsp_valid_d = 1'b1;
              end else begin
                req_d.tile = cmd_in.tile[`CTC_TILE_W-1:0];
                req_d.reg_num = cmd_in.reg_num[`CTC_SWREG_W-1:0];
                state_d = CTC_ST_SW_REQ;
              end
            end
            default: begin
              rsp_valid_d = 1'b1;
              rsp_d.status = 1'b1;
            end
          endcase
        end
      end
      CTC_ST_SW_REQ: begin
        if (req_ready_in) begin
          state_d = CTC_ST_SW_WAIT;
        end
      end
      CTC_ST_SW_WAIT: begin
        if (ack_valid_in) begin
          rsp_valid_d = 1'b1;
          rsp_d = '0;
          if (!ack_in.error) begin
            rsp_d.data = ack_in.data;
            rsp_d.status = 1'b1;
          end
          state_d = CTC_ST_IDLE;
        end
      end
      default: begin
        state_d = CTC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_q <= CTC_ST_IDLE;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      req_q <= req_d;
    end
  end

  assign rsp_valid_out = rsp_valid_q;
  assign rsp_out = rsp_q;
  assign req_valid_out = (state_q == CTC_ST_SW_REQ);
  assign req_out = req_q;

  ctc_sched u_sched (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .active_in(active_in),
    .wait_in(wait_in),
    .fast_in(fast_q),
    .slot_valid_out(slot_valid_out),
    .slot_core_out(slot_core_out),
    .slot_issue_out(slot_issue_out)
  );

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence fast_on_s;
    take && cmd_in.op == CTC_OP_FAST_ON;
  endsequence
  sequence fast_any_s;
    take && (cmd_in.op == CTC_OP_FAST_ON || cmd_in.op == CTC_OP_FAST_OFF);
  endsequence
  sequence sw_start_s;
    take && cmd_in.op == CTC_OP_SW_RD && !sw_ovf;
  endsequence
  sequence ack_ok_s;
    state_q == CTC_ST_SW_WAIT && ack_valid_in && !ack_in.error;
  endsequence
  sequence ack_err_s;
    state_q == CTC_ST_SW_WAIT && ack_valid_in && ack_in.error;
  endsequence

  fast_on_set_a: assert property (fast_on_s |=> fast_q[$past(cmd_in.core)])
    else $error("fast enable did not set issuing core flag");
  others_kept_a: assert property (
    fast_any_s |=> ((fast_q ^ $past(fast_q)) & ~$past(core_mask)) == '0)
    else $error("fast mode change touched another core");
  fast_off_clr_a: assert property (
    take && cmd_in.op == CTC_OP_FAST_OFF |=> !fast_q[$past(cmd_in.core)])
    else $error("fast disable left flag set");
  ps_read_val_a: assert property (
    take && cmd_in.op == CTC_OP_PS_RD && ps_legal
    |=> rsp_valid_out && rsp_out.status && rsp_out.data == $past(ps_rd_val))
    else $error("state read returned wrong value");
  ps_bad_exc_a: assert property (
    take && (cmd_in.op == CTC_OP_PS_RD || cmd_in.op == CTC_OP_PS_WR) && !ps_legal
    |=> rsp_valid_out && rsp_out.exception && !rsp_out.status)
    else $error("illegal state register gave no exception");
  ps_write_val_a: assert property (
    take && cmd_in.op == CTC_OP_PS_WR && ps_legal
    |=> ps_q[$past(ps_idx)] == $past(cmd_in.data) && !rsp_out.exception)
    else $error("state write did not load value");
  sw_req_hold_a: assert property (
    sw_start_s ##1 (!req_ready_in) [*2] |-> req_valid_out && $stable(req_out))
    else $error("switch request dropped before taken");
  sw_ok_data_a: assert property (
    ack_ok_s |=> rsp_valid_out && rsp_out.status && rsp_out.data == $past(ack_in.data))
    else $error("good acknowledgement not returned with status 1");
  sw_err_stat_a: assert property (ack_err_s |=> rsp_valid_out && !rsp_out.status)
    else $error("error acknowledgement not reported as status 0");
  sw_ovf_stat_a: assert property (
    take && cmd_in.op == CTC_OP_SW_RD && sw_ovf
    |=> rsp_valid_out && !rsp_out.status && !req_valid_out && cmd_ready_out)
    else $error("unencodable switch read not refused");
  fast_reset_a: assert property (
    @(posedge ref_clk_in) disable iff (1'b0) !resetn_in |=> fast_q == '0)
    else $error("fast flags not cleared by reset");
endmodule
`default_nettype wire

// [bench/ctc_sw_model.sv]
// Behavioural processor switch answering register read requests
`timescale 1ns/1ps
`default_nettype none
module ctc_sw_model
  import ctc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] delay_in,
  input wire logic err_in,
  input wire logic req_valid_in,
  input wire ctc_swreq_t req_in,
  output logic req_ready_out,
  output logic ack_valid_out,
  output ctc_swack_t ack_out
);
  logic [3:0] cnt;
  logic [31:0] dat;
  logic err;
  // Released ack lines show the inverse of the last value
  assign ack_out = ack_valid_out ? {err, dat} : {~err, ~dat};
  always @(posedge ref_clk_in) begin
    ack_valid_out <= 1'b0;
    if (!resetn_in) begin
      req_ready_out <= 1'b0;
      cnt <= 4'h0;
      dat <= 32'h0;
      err <= 1'b0;
    end else if (req_ready_out) begin
      req_ready_out <= 1'b0;
      cnt <= 4'h0;
      ack_valid_out <= 1'b1;
      dat <= err_in ? 32'h0 : {req_in.tile, 8'ha5, req_in.reg_num};
      err <= err_in;
    end else if (req_valid_in) begin
      cnt <= cnt + 4'h1;
      if (cnt >= delay_in) begin
        req_ready_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/ctc_top_tb_top.sv]
// Self-checking testbench for the core tile control block
`timescale 1ns/1ps
`default_nettype none
module ctc_top_tb_top;
  import ctc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  ctc_cmd_t cmd_in = '0;
  logic [7:0] active_in = 8'h00;
  logic [7:0] wait_in = 8'h00;
  logic [3:0] dly = 4'h0;
  logic err = 1'b0;
  logic cmd_ready_out, rsp_valid_out, slot_valid_out, slot_issue_out;
  logic req_valid_out, req_ready_in, ack_valid_in;
  logic [7:0] fast_out;
  logic [2:0] slot_core_out;
  ctc_rsp_t rsp_out, rsp;
  ctc_swreq_t req_out;
  ctc_swack_t ack_in;
  int errors = 0;
  int n_compared = 0;
  int n_req = 0;
  ctc_top uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_out(rsp_out), .active_in(active_in), .wait_in(wait_in), .fast_out(fast_out),
    .slot_valid_out(slot_valid_out), .slot_core_out(slot_core_out),
    .slot_issue_out(slot_issue_out), .req_valid_out(req_valid_out), .req_out(req_out),
    .req_ready_in(req_ready_in), .ack_valid_in(ack_valid_in), .ack_in(ack_in));
  ctc_sw_model sw (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .delay_in(dly),
    .err_in(err), .req_valid_in(req_valid_out), .req_in(req_out),
    .req_ready_out(req_ready_in), .ack_valid_out(ack_valid_in), .ack_out(ack_in));
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    if (req_valid_out === 1'b1 && req_ready_in === 1'b1) begin
      n_req++;
    end
  end
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cmd(input ctc_op_t op, input logic [2:0] c, input logic [31:0] r, d, t);
    int i;
    @(posedge ref_clk_in);
    cmd_in <= '{op, c, r, d, t};
    cmd_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    while (cmd_ready_out !== 1'b1) begin
      @(posedge ref_clk_in);
    end
    cmd_valid_in <= 1'b0;
    i = 0;
    #1;
    while (rsp_valid_out !== 1'b1 && i < 40) begin
      chk(cmd_ready_out === 1'b0, "ready while switch read pending");
      @(posedge ref_clk_in);
      #1;
      i++;
    end
    rsp = rsp_out;
    chk(i < 40 && cmd_ready_out === 1'b1, "no response");
  endtask
  task automatic t_reset_mid;
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    chk(fast_out === 8'h00 && rsp_valid_out === 1'b0 && cmd_ready_out === 1'b1, "mid reset");
    cmd(CTC_OP_PS_RD, 3'h1, 32'h3, 32'h0, 32'h0);
    chk(rsp.data === 32'h0 && rsp.status === 1'b1, "state register after reset");
  endtask
  task t_reset;
    @(posedge ref_clk_in);
    #1;
    chk(fast_out === 8'h00, "fast flags set after reset");
  endtask
  task automatic t_fast;
    logic [7:0] e;
    int c;
    e = 8'h00;
    for (c = 0; c < 8; c++) begin
      cmd(CTC_OP_FAST_ON, c[2:0], 32'h0, 32'h0, 32'h0);
      e[c] = 1'b1;
      chk(fast_out === e && rsp.status === 1'b1, "fast on");
    end
    for (c = 7; c > 1; c--) begin
      cmd(CTC_OP_FAST_OFF, c[2:0], 32'h0, 32'h0, 32'h0);
      e[c] = 1'b0;
      chk(fast_out === e && rsp.status === 1'b1, "fast off");
    end
    cmd(CTC_OP_NOP, 3'h5, 32'h0, 32'h0, 32'h0);
    chk(fast_out === e && rsp.status === 1'b1, "nop changed flags");
  endtask
  task automatic t_ps;
    int r;
    for (r = 0; r < 8; r++) begin
      cmd(CTC_OP_PS_WR, 3'h1, r, 32'hc0de0000 + r, 32'h0);
      chk(rsp.exception === 1'b0 && rsp.status === 1'b1, "state write");
    end
    cmd(CTC_OP_PS_WR, 3'h1, 32'h8, 32'hdead0000, 32'h0);
    chk(rsp.exception === 1'b1 && rsp.status === 1'b0, "illegal write");
    for (r = 0; r < 8; r++) begin
      cmd(CTC_OP_PS_RD, 3'h1, r, 32'h0, 32'h0);
      chk(rsp.data === 32'hc0de0000 + r && rsp.exception === 1'b0, "state read");
    end
    cmd(CTC_OP_PS_RD, 3'h1, 32'h8, 32'h0, 32'h0);
    chk(rsp.exception === 1'b1, "illegal read 8");
    cmd(CTC_OP_PS_RD, 3'h1, 32'h80000002, 32'h0, 32'h0);
    chk(rsp.exception === 1'b1, "illegal read high");
  endtask
  task automatic t_sched;
    int g[8];
    int i;
    g = '{default: 0};
    @(posedge ref_clk_in);
    active_in <= 8'hff;
    wait_in <= 8'h0f;
    repeat (2) @(posedge ref_clk_in);
    for (i = 0; i < 24; i++) begin
      @(posedge ref_clk_in);
      #1;
      if (slot_valid_out === 1'b1) begin
        g[slot_core_out]++;
        chk(slot_issue_out === (slot_core_out > 3'h3), "issue flag");
      end
    end
    chk(g[2] + g[3] == 0, "waiting normal core granted");
    chk(g[0] >= 3 && g[1] >= 3 && g[7] >= 3, "slot not reserved");
    @(posedge ref_clk_in);
    active_in <= 8'h00;
    wait_in <= 8'h00;
  endtask
  task automatic t_sw;
    int n;
    n = n_req;
    cmd(CTC_OP_SW_RD, 3'h2, 32'h56, 32'h0, 32'h1234);
    chk(rsp.status === 1'b1 && rsp.data === 32'h1234a556, "good read");
    chk(n_req == n + 1, "good read sent no single request");
    dly = 4'h5;
    cmd(CTC_OP_SW_RD, 3'h2, 32'hff, 32'h0, 32'hffff);
    chk(rsp.status === 1'b1 && rsp.data === 32'hffffa5ff, "slow read");
    err = 1'b1;
    cmd(CTC_OP_SW_RD, 3'h2, 32'h1, 32'h0, 32'h2);
    chk(rsp.status === 1'b0 && rsp.data === 32'h0, "error ack");
    err = 1'b0;
    n = n_req;
    cmd(CTC_OP_SW_RD, 3'h2, 32'h100, 32'h0, 32'h1);
    chk(rsp.status === 1'b0 && rsp.data === 32'h0, "register too large");
    cmd(CTC_OP_SW_RD, 3'h2, 32'h1, 32'h0, 32'h10000);
    chk(rsp.status === 1'b0, "tile too large");
    chk(n_req == n, "request sent for unencodable read");
  endtask
  task report_and_stop;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_fast();
    t_ps();
    t_sched();
    t_reset_mid();
    t_sw();
    report_and_stop();
  end
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
